// ===== rtl/bld_ctrl.sv
// Module: backlight dimming, ramp sequencing and LED fault control
// Function
// - Dimming input polarity by bit, default high
// - Sample dimming input at 20MHz, DC output
// - Measured duty becomes an 11-bit code
// - Duty changes ramp at 3-bit selected slope
// - No dimming pulse turns boost off
// - Duty code readable, low then high register
// - Hysteresis is twice the 3-bit setting
// - Hysteresis only when direction reverses
// - On/off ramps from 4-bit time fields
// - Ramp shape linear or exponential by bit
// - Short over 59ms flags, optionally disables channel
// - Short response off: flag only, keep regulating
// - Overvoltage stops boost and sets flag
// - Response off: resume switching below threshold
// - Response on: disable low-headroom sinks until restart
// - All channels open: halt until restart
// - 2-bit current limit; trip blanks rest of cycle
// - Enough limit events set overcurrent flag
// - Duty times brightness; zero duty means standby
// - Brightness mode bit: register only or combined
`timescale 1ns/100ps
`default_nettype none
module bld_ctrl #(
    parameter int unsigned RAMP_MIN_CYCLES = bld_pkg::BLD_RAMP_MIN_CYC, // Shortest ramp
    parameter int unsigned RAMP_UNIT_CYCLES = bld_pkg::BLD_RAMP_UNIT_CYC, // Ramp time unit
    parameter int unsigned SHORT_CYCLES = bld_pkg::BLD_SHORT_FILTER_CYC, // Short filter
    parameter int unsigned TIMEOUT_CYCLES = bld_pkg::BLD_PWM_TIMEOUT_CYC, // No-pulse time
    parameter int unsigned OCP_EVENTS = bld_pkg::BLD_OCP_EVENTS // Events to flag
) (
    input wire logic MCLK, // 100 MHz clock
    input wire logic NRST, // Async reset, active low
    input wire logic HARDWARE_ENABLE_PIN, // Low holds the block in reset
    input wire logic PWM_IN, // Dimming input
    input wire logic REG_WE, // Register write strobe
    input wire logic REG_RE, // Register read strobe
    input wire logic [7:0] REG_ADDR, // Register offset
    input wire logic [7:0] REG_WDATA, // Write data
    output logic [7:0] REG_RDATA, // Read data
    input wire logic [5:0] SINK_SHORT_DET, // Sink above sink_short_threshold
    input wire logic [5:0] SINK_LOW_HEADROOM, // Sink headroom low
    input wire logic BOOST_OVP_DET, // Output over threshold
    input wire logic LS_OCP_TRIP, // Low-side current limit trip
    input wire logic SW_CYCLE_START, // Switching cycle start pulse
    output logic BOOST_EN, // Boost may switch
    output logic LS_GATE_OFF, // Low-side switch held off
    output logic [5:0] SINK_EN, // Current sink enables
    output logic [1:0] OCP_LIMIT_SEL, // Current limit select
    output logic [10:0] ILED_CODE // Sink current code
);
    import bld_pkg::*;

    typedef struct packed {
        logic [7:0] mode; // Mode register
        logic [2:0] hyst; // Hysteresis setting
        logic [2:0] brt_lo; // Brightness low bits
        logic [7:0] brt_hi; // Brightness high bits
        logic [6:0] ctrl; // Enable and sink mask
        logic short_resp; // sink_fault_response_select
        logic [1:0] ocp_sel; // Current limit select
        logic [7:0] ramp; // On/off ramp times
        logic [2:0] trans; // Transition slope
        logic [2:0] flags; // Fault flags
        logic [7:0] rdata; // Read data
        bld_state_t state; // Sequencer state
        logic [10:0] level; // Applied current code
        logic [23:0] step_cnt; // Ramp step timer
        logic [5:0][22:0] short_cnt; // Short filters
        logic [5:0] short_off; // Sinks off for short
        logic [5:0] open_off; // Sinks off for open
        logic ls_off; // Low-side blanked
        logic [3:0] ocp_cnt; // Limit events seen
        logic trip_prev; // Trip last cycle
    } bld_ctl_t;

    localparam bld_ctl_t RST_VAL = '{
        mode: BLD_RST_MODE, hyst: BLD_RST_HYST, brt_lo: BLD_RST_BRT_LO,
        brt_hi: BLD_RST_BRT_HI, ctrl: BLD_RST_BL_CTRL, short_resp: 1'b0,
        ocp_sel: BLD_RST_OCP, ramp: BLD_RST_RAMP, trans: BLD_RST_TRANS,
        flags: 3'h0, rdata: 8'h00, state: ST_OFF, level: 11'h000,
        step_cnt: 24'h0, short_cnt: '0, short_off: 6'h00, open_off: 6'h00,
        ls_off: 1'b0, ocp_cnt: 4'h0, trip_prev: 1'b0
    };

    bld_ctl_t q, n;
    logic meter_clr; // Clears duty measurement
    logic meas_valid; // New measured code
    logic [10:0] meas_code; // Raw measured code
    logic [10:0] duty_app; // Code after hysteresis
    logic no_pulse; // Dimming timeout

    // Ramp step period for a 4-bit time field, one full-scale ramp over it
    function automatic logic [23:0] ramp_interval(input logic [3:0] sel);
        logic [47:0] t;
        if (sel == 4'h0) t = 48'(RAMP_MIN_CYCLES);
        else t = 48'(RAMP_UNIT_CYCLES) << (sel - 4'h1);
        return (t[34:11] == 24'h0) ? 24'h1 : t[34:11];
    endfunction : ramp_interval

    // Move a code toward a goal by at most amt
    function automatic logic [10:0] step_to(input logic [10:0] cur, input logic [10:0] goal,
                                            input logic [10:0] amt);
        if (cur < goal) return ((goal - cur) > amt) ? 11'(cur + amt) : goal;
        else return ((cur - goal) > amt) ? 11'(cur - amt) : goal;
    endfunction : step_to

    assign meter_clr = !HARDWARE_ENABLE_PIN || !q.mode[BLD_BIT_PWM_EN];

    // Duty measurement
    bld_duty_meter #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
    ) u_meter (
        .clk(MCLK),
        .rst_n(NRST),
        .clr(meter_clr),
        .pwm_in(PWM_IN),
        .active_low(q.mode[BLD_BIT_POL_LOW]),
        .code_valid(meas_valid),
        .code(meas_code),
        .no_pulse(no_pulse)
    );

    // Hysteresis on the measured code
    bld_duty_hyst u_hyst (
        .clk(MCLK),
        .rst_n(NRST),
        .clr(meter_clr),
        .in_valid(meas_valid),
        .in_code(meas_code),
        .hyst_sel(q.hyst),
        .out_code(duty_app)
    );

    // Next state of registers, sequencer and fault logic
    always_comb begin
        logic pwm_en;
        logic [10:0] brt;
        logic [21:0] prod;
        logic [10:0] target;
        logic standby;
        logic running;
        logic [5:0] act;
        logic [23:0] interval;
        logic tick;
        logic [10:0] amt;
        pwm_en = q.mode[BLD_BIT_PWM_EN];
        brt = {q.brt_hi, q.brt_lo};
        prod = 22'(brt * duty_app) + {11'h000, brt};
        target = pwm_en ? prod[21:11] : brt;
        standby = !q.ctrl[BLD_BIT_BL_EN] || brt == 11'h000 || q.ctrl[5:0] == 6'h00
            || (pwm_en && duty_app == 11'h000);
        running = q.state == ST_RAMP_UP || q.state == ST_ON || q.state == ST_RAMP_DN;
        act = q.ctrl[5:0] & ~q.short_off & ~q.open_off;
        n = q;

        // Register writes
        if (REG_WE) begin
            case (REG_ADDR)
                BLD_OFS_MODE: n.mode = REG_WDATA;
                BLD_OFS_HYST: n.hyst = REG_WDATA[2:0];
                BLD_OFS_BRT_LO: n.brt_lo = REG_WDATA[2:0];
                BLD_OFS_BRT_HI: n.brt_hi = REG_WDATA;
                BLD_OFS_BL_CTRL: n.ctrl = REG_WDATA[6:0];
                BLD_OFS_SINK_CFG: n.short_resp = REG_WDATA[BLD_BIT_SHORT_RESP];
                BLD_OFS_OCP_CFG: n.ocp_sel = REG_WDATA[1:0];
                BLD_OFS_RAMP: n.ramp = REG_WDATA;
                BLD_OFS_TRANS: n.trans = REG_WDATA[2:0];
                default: ; // Others ignored
            endcase
        end

        // Register reads, data valid the cycle after the strobe
        if (REG_RE) begin
            case (REG_ADDR)
                BLD_OFS_MODE: n.rdata = q.mode;
                BLD_OFS_HYST: n.rdata = {5'h00, q.hyst};
                BLD_OFS_BRT_LO: n.rdata = {5'h00, q.brt_lo};
                BLD_OFS_BRT_HI: n.rdata = q.brt_hi;
                BLD_OFS_BL_CTRL: n.rdata = {1'b0, q.ctrl};
                BLD_OFS_STATUS: n.rdata = {5'h00, q.flags};
                BLD_OFS_SINK_CFG: n.rdata = {q.short_resp, 7'h00};
                BLD_OFS_OCP_CFG: n.rdata = {6'h00, q.ocp_sel};
                BLD_OFS_DUTY_LO: n.rdata = meas_code[7:0];
                BLD_OFS_DUTY_HI: n.rdata = {5'h00, meas_code[10:8]};
                BLD_OFS_RAMP: n.rdata = q.ramp;
                BLD_OFS_TRANS: n.rdata = {5'h00, q.trans};
                default: n.rdata = 8'h00; // Unmapped reads zero
            endcase
            // Reading status clears the flags; new events below still win
            if (REG_ADDR == BLD_OFS_STATUS) n.flags = 3'h0;
        end

        // Step timer: on/off ramps use their fields, otherwise the transition slope
        case (q.state)
            ST_RAMP_UP: interval = ramp_interval(q.ramp[7:4]);
            ST_RAMP_DN: interval = ramp_interval(q.ramp[3:0]);
            default: interval = 24'(BLD_TRANS_STEP_CYC) << q.trans;
        endcase
        tick = (q.step_cnt + 24'h1) >= interval;
        n.step_cnt = tick ? 24'h0 : q.step_cnt + 24'h1;
        // Exponential shape steps in proportion to the present level
        amt = q.mode[BLD_BIT_EXP] ? {6'h00, q.level[10:6]} + 11'h001 : 11'h001;

        // Output sequencer
        case (q.state)
            ST_OFF: begin
                n.level = 11'h000;
                if (!standby) n.state = ST_RAMP_UP;
            end
            ST_RAMP_UP: begin
                if (standby) n.state = ST_RAMP_DN;
                else if (q.level == target) n.state = ST_ON;
                else if (tick) n.level = step_to(q.level, target, amt);
            end
            ST_ON: begin
                if (standby) n.state = ST_RAMP_DN;
                else if (tick) n.level = step_to(q.level, target, 11'h001);
            end
            ST_RAMP_DN: begin
                if (!standby) n.state = ST_RAMP_UP;
                else if (q.level == 11'h000) n.state = ST_OFF;
                else if (tick) n.level = step_to(q.level, 11'h000, amt);
            end
            ST_HALT: begin
                n.level = 11'h000;
                if (!q.ctrl[BLD_BIT_BL_EN]) n.state = ST_OFF;
            end
            default: n.state = ST_OFF;
        endcase

        // Short filters per sink
        for (int i = 0; i < 6; i++) begin
            if (SINK_SHORT_DET[i] && act[i] && running) begin
                if (q.short_cnt[i] >= 23'(SHORT_CYCLES)) begin
                    n.flags[BLD_BIT_SHORT] = 1'b1;
                    if (q.short_resp) n.short_off[i] = 1'b1;
                end else begin
                    n.short_cnt[i] = q.short_cnt[i] + 23'h1;
                end
            end else begin
                n.short_cnt[i] = 23'h0;
            end
        end

        // Overvoltage handling
        if (BOOST_OVP_DET && running) begin
            n.flags[BLD_BIT_OVP] = 1'b1;
            if (q.mode[BLD_BIT_OVP_RESP]) begin
                n.open_off = q.open_off | (act & SINK_LOW_HEADROOM);
            end
            if ((act & ~SINK_LOW_HEADROOM) == 6'h00) begin
                n.open_off = q.open_off | act;
                n.state = ST_HALT;
            end
        end

        // Backlight mode restart releases latched sinks
        if (!q.ctrl[BLD_BIT_BL_EN]) begin
            n.short_off = 6'h00;
            n.open_off = 6'h00;
        end

        // Current limit: blank the rest of the cycle, count events
        n.ls_off = (q.ls_off && !SW_CYCLE_START) || LS_OCP_TRIP;
        n.trip_prev = LS_OCP_TRIP;
        if (LS_OCP_TRIP && !q.trip_prev) begin
            if (q.ocp_cnt >= 4'(OCP_EVENTS - 1)) begin
                n.flags[BLD_BIT_OCP] = 1'b1;
                n.ocp_cnt = 4'h0;
            end else begin
                n.ocp_cnt = q.ocp_cnt + 4'h1;
            end
        end

        // Hardware enable low or soft reset restores defaults
        if (!HARDWARE_ENABLE_PIN
            || (REG_WE && REG_ADDR == BLD_OFS_BL_CTRL && REG_WDATA[BLD_BIT_SRST])) begin
            n = RST_VAL;
        end
    end

    // State register
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            q <= RST_VAL;
        end else begin
            q <= n;
        end
    end

    // Outputs
    always_comb begin
        logic running;
        running = q.state == ST_RAMP_UP || q.state == ST_ON || q.state == ST_RAMP_DN;
        SINK_EN = running ? (q.ctrl[5:0] & ~q.short_off & ~q.open_off) : 6'h00;
        BOOST_EN = running && !BOOST_OVP_DET && SINK_EN != 6'h00
            && !(q.mode[BLD_BIT_PWM_EN] && no_pulse);
    end

    assign LS_GATE_OFF = q.ls_off || LS_OCP_TRIP;
    assign OCP_LIMIT_SEL = q.ocp_sel;
    assign ILED_CODE = q.level;
    assign REG_RDATA = q.rdata;
endmodule : bld_ctrl
`default_nettype wire

// ===== rtl/bld_duty_hyst.sv
// Module: direction-aware hysteresis on the measured duty code
`timescale 1ns/100ps
`default_nettype none
module bld_duty_hyst (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic clr, // Sync clear
    input wire logic in_valid, // New measured code
    input wire logic [10:0] in_code, // Measured code
    input wire logic [2:0] hyst_sel, // Hysteresis setting
    output logic [10:0] out_code // Applied code
);
    import bld_pkg::*;

    typedef struct packed {
        logic [10:0] code; // Applied code
        logic up; // Last direction was up
        logic have_dir; // Direction known
    } bld_hyst_t;

    bld_hyst_t q, n;

    // Follow freely in the same direction, hold on a reversal
    always_comb begin
        logic [10:0] band;
        band = {7'h00, hyst_sel, 1'b0};
        n = q;
        if (in_valid) begin
            if (in_code > q.code) begin
                if (!q.have_dir || q.up || (in_code - q.code) >= band) begin
                    n.code = in_code;
                    n.up = 1'b1;
                    n.have_dir = 1'b1;
                end
            end else if (in_code < q.code) begin
                if (!q.have_dir || !q.up || (q.code - in_code) >= band) begin
                    n.code = in_code;
                    n.up = 1'b0;
                    n.have_dir = 1'b1;
                end
            end
        end
        if (clr) n = '0;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) q <= '0;
        else q <= n;
    end

    assign out_code = q.code;
endmodule : bld_duty_hyst
`default_nettype wire

// ===== rtl/bld_duty_meter.sv
// Module: dimming input duty measurement at the 20 MHz sample rate
`timescale 1ns/100ps
`default_nettype none
module bld_duty_meter #(
    parameter int unsigned TIMEOUT_CYCLES = bld_pkg::BLD_PWM_TIMEOUT_CYC // No-pulse timeout
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic clr, // Sync clear
    input wire logic pwm_in, // Raw dimming input
    input wire logic active_low, // Polarity select
    output logic code_valid, // New code pulse
    output logic [10:0] code, // Measured duty code
    output logic no_pulse // No pulse seen
);
    import bld_pkg::*;

    typedef struct packed {
        logic [2:0] div; // Sample tick divider
        logic prev; // Previous sample
        logic [17:0] hi_cnt; // Active samples
        logic [17:0] per_cnt; // Period samples
        logic [17:0] per_lat; // Divisor
        logic [18:0] rem; // Division remainder
        logic [3:0] bits; // Quotient bits left
        logic busy; // Divider running
        logic [10:0] quo; // Partial quotient
        logic [10:0] code; // Result
        logic valid; // Result pulse
        logic [23:0] idle; // Cycles since rising edge
        logic no_pulse; // Timeout flag
    } bld_meter_t;

    bld_meter_t q, n;

    // Next state: sampling, division and timeout
    always_comb begin
        logic smp;
        logic [18:0] r2;
        smp = pwm_in ^ active_low;
        r2 = {q.rem[17:0], 1'b0};
        n = q;
        n.valid = 1'b0;
        // Serial divider: active/period as an 11-bit fraction
        if (q.busy) begin
            n.bits = q.bits - 4'h1;
            if (r2 >= {1'b0, q.per_lat}) begin
                n.rem = r2 - {1'b0, q.per_lat};
                n.quo = {q.quo[9:0], 1'b1};
            end else begin
                n.rem = r2;
                n.quo = {q.quo[9:0], 1'b0};
            end
            if (q.bits == 4'h1) begin
                n.busy = 1'b0;
                n.code = n.quo;
                n.valid = 1'b1;
            end
        end
        // No rising edge for too long: report steady level and stop the boost
        if (q.idle >= 24'(TIMEOUT_CYCLES - 1)) begin
            n.no_pulse = 1'b1;
            if (!q.no_pulse) begin
                n.code = smp ? BLD_CODE_MAX : 11'h000;
                n.valid = 1'b1;
                n.per_cnt = 18'h00000;
                n.hi_cnt = 18'h00000;
            end
        end else begin
            n.idle = q.idle + 24'h1;
        end
        // 20 MHz sample tick
        if (q.div >= 3'(BLD_SAMPLE_DIV - 1)) begin
            n.div = 3'h0;
            n.prev = smp;
            if (smp && !q.prev) begin
                n.per_cnt = 18'h00001;
                n.hi_cnt = 18'h00001;
                n.idle = 24'h0;
                n.no_pulse = 1'b0;
                if (q.per_cnt == 18'h00000) begin
                    n.busy = 1'b0; // First edge: no full period yet
                end else if (q.hi_cnt >= q.per_cnt) begin
                    n.code = BLD_CODE_MAX;
                    n.valid = 1'b1;
                end else begin
                    n.busy = 1'b1;
                    n.bits = 4'hB;
                    n.rem = {1'b0, q.hi_cnt};
                    n.per_lat = q.per_cnt;
                    n.quo = 11'h000;
                end
            end else begin
                if (q.per_cnt != BLD_PER_MAX) n.per_cnt = q.per_cnt + 18'h1;
                if (smp && q.hi_cnt != BLD_PER_MAX) n.hi_cnt = q.hi_cnt + 18'h1;
            end
        end else begin
            n.div = q.div + 3'h1;
        end
        if (clr) n = '0;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) q <= '0;
        else q <= n;
    end

    assign code_valid = q.valid;
    assign code = q.code;
    assign no_pulse = q.no_pulse;
endmodule : bld_duty_meter
`default_nettype wire

// ===== rtl/bld_pkg.sv
// Package: constants and types for the backlight dimming and fault controller
package bld_pkg;
    // Register offsets
    localparam logic [7:0] BLD_OFS_MODE = 8'h02;
    localparam logic [7:0] BLD_OFS_HYST = 8'h03;
    localparam logic [7:0] BLD_OFS_BRT_LO = 8'h04;
    localparam logic [7:0] BLD_OFS_BRT_HI = 8'h05;
    localparam logic [7:0] BLD_OFS_BL_CTRL = 8'h08;
    localparam logic [7:0] BLD_OFS_STATUS = 8'h0F;
    localparam logic [7:0] BLD_OFS_SINK_CFG = 8'h10;
    localparam logic [7:0] BLD_OFS_OCP_CFG = 8'h11;
    localparam logic [7:0] BLD_OFS_DUTY_LO = 8'h12;
    localparam logic [7:0] BLD_OFS_DUTY_HI = 8'h13;
    localparam logic [7:0] BLD_OFS_RAMP = 8'h14;
    localparam logic [7:0] BLD_OFS_TRANS = 8'h15;
    // Field positions
    localparam int unsigned BLD_BIT_PWM_EN = 0;
    localparam int unsigned BLD_BIT_EXP = 1;
    localparam int unsigned BLD_BIT_POL_LOW = 2;
    localparam int unsigned BLD_BIT_OVP_RESP = 7;
    localparam int unsigned BLD_BIT_BL_EN = 6;
    localparam int unsigned BLD_BIT_SRST = 7;
    localparam int unsigned BLD_BIT_SHORT_RESP = 7;
    localparam int unsigned BLD_BIT_OCP = 0;
    localparam int unsigned BLD_BIT_OVP = 1;
    localparam int unsigned BLD_BIT_SHORT = 2;
    // Reset values
    localparam logic [7:0] BLD_RST_MODE = 8'h00;
    localparam logic [2:0] BLD_RST_HYST = 3'h0;
    localparam logic [2:0] BLD_RST_BRT_LO = 3'h7;
    localparam logic [7:0] BLD_RST_BRT_HI = 8'h00;
    localparam logic [6:0] BLD_RST_BL_CTRL = 7'h00;
    localparam logic [1:0] BLD_RST_OCP = 2'h0;
    localparam logic [7:0] BLD_RST_RAMP = 8'h44;
    localparam logic [2:0] BLD_RST_TRANS = 3'h0;
    // Timing
    localparam int unsigned BLD_CLK_HZ = 100_000_000;
    localparam int unsigned BLD_SAMPLE_HZ = 20_000_000;
    localparam int unsigned BLD_SAMPLE_DIV = BLD_CLK_HZ / BLD_SAMPLE_HZ;
    localparam int unsigned BLD_SHORT_FILTER_MS = 59;
    localparam int unsigned BLD_SHORT_FILTER_CYC = BLD_SHORT_FILTER_MS * (BLD_CLK_HZ / 1000);
    localparam int unsigned BLD_PWM_TIMEOUT_MS = 20;
    localparam int unsigned BLD_PWM_TIMEOUT_CYC = BLD_PWM_TIMEOUT_MS * (BLD_CLK_HZ / 1000);
    localparam int unsigned BLD_RAMP_MIN_US = 512;
    localparam int unsigned BLD_RAMP_MIN_CYC = BLD_RAMP_MIN_US * (BLD_CLK_HZ / 1_000_000);
    localparam int unsigned BLD_RAMP_UNIT_MS = 1;
    localparam int unsigned BLD_RAMP_UNIT_CYC = BLD_RAMP_UNIT_MS * (BLD_CLK_HZ / 1000);
    localparam int unsigned BLD_TRANS_STEP_NS = 500;
    localparam int unsigned BLD_TRANS_STEP_CYC = BLD_TRANS_STEP_NS * (BLD_CLK_HZ / 1_000_000) / 1000;
    localparam int unsigned BLD_OCP_EVENTS = 8;
    // Code limits
    localparam logic [10:0] BLD_CODE_MAX = 11'h7FF;
    localparam logic [17:0] BLD_PER_MAX = 18'h3FFFF;
    // Output sequencer states
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_RAMP_UP = 3'b001,
        ST_ON = 3'b010,
        ST_RAMP_DN = 3'b011,
        ST_HALT = 3'b100
    } bld_state_t;
endpackage : bld_pkg

// ===== testbench/bld_ctrl_assertions.sv
// Port checker for bld_ctrl
`timescale 1ns/100ps
`default_nettype none
module bld_ctrl_chk (
    input wire logic MCLK, // Clock
    input wire logic NRST, // Reset
    input wire logic HARDWARE_ENABLE_PIN, // Enable
    input wire logic REG_WE, // Write
    input wire logic REG_RE, // Read
    input wire logic [7:0] REG_ADDR, // Offset
    input wire logic [7:0] REG_WDATA, // Data
    input wire logic [7:0] REG_RDATA, // Answer
    input wire logic BOOST_OVP_DET, // Overvoltage
    input wire logic LS_OCP_TRIP, // Trip
    input wire logic SW_CYCLE_START, // Cycle
    input wire logic BOOST_EN, // Boost
    input wire logic LS_GATE_OFF, // Gate
    input wire logic [5:0] SINK_EN, // Sinks
    input wire logic [1:0] OCP_LIMIT_SEL, // Limit
    input wire logic [10:0] ILED_CODE // Current
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    wire en = HARDWARE_ENABLE_PIN; // Block enabled
    trip_off_a: assert property (LS_OCP_TRIP |-> LS_GATE_OFF) else $error("trip");
    blank_hold_a: assert property (LS_GATE_OFF && !SW_CYCLE_START && en |=> LS_GATE_OFF)
        else $error("blank");
    ovp_stop_a: assert property (BOOST_OVP_DET |-> !BOOST_EN) else $error("ovp");
    no_sink_a: assert property (SINK_EN == 6'h00 |-> !BOOST_EN) else $error("sinks");
    limit_set_a: assert property (REG_WE && REG_ADDR == 8'h11 && en
        |=> OCP_LIMIT_SEL == $past(REG_WDATA[1:0])) else $error("limit");
    limit_keep_a: assert property (!REG_WE && en |=> $stable(OCP_LIMIT_SEL)) else $error("keep");
    read_keep_a: assert property (!REG_RE && en |=> $stable(REG_RDATA)) else $error("rdata");
    hw_clear_a: assert property (!en |=> SINK_EN == 6'h00 && ILED_CODE == 11'h000)
        else $error("hardware_enable_pin");
    cover property (LS_OCP_TRIP && !SW_CYCLE_START);
    cover property (REG_RE && REG_ADDR == 8'h12);
    cover property (!en);
endmodule : bld_ctrl_chk
bind bld_ctrl bld_ctrl_chk bld_ctrl_chk_i (.MCLK(MCLK), .NRST(NRST),
    .HARDWARE_ENABLE_PIN(HARDWARE_ENABLE_PIN), .REG_WE(REG_WE), .REG_RE(REG_RE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .BOOST_OVP_DET(BOOST_OVP_DET), .LS_OCP_TRIP(LS_OCP_TRIP), .SW_CYCLE_START(SW_CYCLE_START),
    .BOOST_EN(BOOST_EN), .LS_GATE_OFF(LS_GATE_OFF), .SINK_EN(SINK_EN),
    .OCP_LIMIT_SEL(OCP_LIMIT_SEL), .ILED_CODE(ILED_CODE));
`default_nettype wire

// ===== testbench/bld_pwm_host.sv
// Host model driving the dimming line
`timescale 1ns/100ps
`default_nettype none
module bld_pwm_host #(
    parameter int unsigned PER = 1000, // Period, 100 kHz
    parameter int unsigned ON = 250 // Active time
) (
    input wire logic clk, // Clock
    input wire logic run, // Pulsing
    output logic pwm // Dimming line
);
    int unsigned cnt = 0; // Place in period
    initial pwm = 1'b0;
    // Pulse train moves off the sampling edge; idle low
    always @(negedge clk) begin
        cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
        pwm <= run && cnt < ON;
    end
endmodule : bld_pwm_host
`default_nettype wire

// ===== testbench/test_bld_ctrl.sv
// Bench for bld_ctrl
`timescale 1ns/100ps
`default_nettype none
module test_bld_ctrl;
    logic clk = 0, nrst = 0, hw = 1, we = 0, re = 0, trip = 0, cs = 0, run = 0, rd_d = 0;
    logic [7:0] a = 8'h00, wd = 8'h00, rdat, rnd;
    logic pwm, ben, goff;
    logic [5:0] sht = 6'h00, snk; // Short detect drive, sink enables seen
    logic [10:0] iled; // Applied current code seen
    logic [1:0] lim;
    logic [7:0] eq[$]; // Expected read data
    int mismatches = 0, samples_checked = 0, cyc = 0, seed = 32'h2d78;
    bld_pwm_host bld_pwm_host_i (.clk(clk), .run(run), .pwm(pwm));
    bld_ctrl #(.SHORT_CYCLES(50), .TIMEOUT_CYCLES(2000), .OCP_EVENTS(4)) bld_ctrl_i (
        .MCLK(clk), .NRST(nrst), .HARDWARE_ENABLE_PIN(hw), .PWM_IN(pwm), .REG_WE(we),
        .REG_RE(re), .REG_ADDR(a), .REG_WDATA(wd), .REG_RDATA(rdat), .SINK_SHORT_DET(sht),
        .SINK_LOW_HEADROOM(6'h00), .BOOST_OVP_DET(trip), .LS_OCP_TRIP(trip), .SW_CYCLE_START(cs),
        .BOOST_EN(ben), .LS_GATE_OFF(goff), .SINK_EN(snk), .OCP_LIMIT_SEL(lim), .ILED_CODE(iled));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(string n, logic [10:0] s, logic [10:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic wr(logic [7:0] ad, logic [7:0] d);
        @(negedge clk) {we, a, wd} = {1'b1, ad, d};
        @(negedge clk) we = 0;
    endtask : wr
    task automatic rd(logic [7:0] ad, logic [7:0] e);
        eq.push_back(e);
        @(negedge clk) {re, a} = {1'b1, ad};
        @(negedge clk) re = 0;
    endtask : rd
    // Watcher: each answer meets the oldest note; a hang ends the run
    always @(posedge clk) rd_d <= re;
    always @(negedge clk) begin
        cyc++;
        if (rd_d) chk("rdata", {3'h0, rdat}, {3'h0, eq.pop_front()});
        if (cyc == 30000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    initial begin
        rnd = 8'($random(seed));
        repeat (10) @(negedge clk);
        nrst = 1;
        rd(8'h14, 8'h44);
        wr(8'h14, rnd);
        rd(8'h14, rnd);
        for (int i = 0; i < 4; i++) begin
            wr(8'h11, 8'(i));
            chk("limit", {9'h000, lim}, 11'(i));
        end
        repeat (4) begin
            @(negedge clk) trip = 1;
            @(negedge clk) trip = 0;
            chk("blank", {10'h000, goff}, 11'h001);
            cs = 1;
            @(negedge clk) cs = 0;
            chk("gate", {10'h000, goff}, 11'h000);
        end
        rd(8'h0F, 8'h01);
        rd(8'h0F, 8'h00);
        wr(8'h03, 8'h06);
        wr(8'h08, 8'h41);
        wr(8'h02, 8'h01);
        run = 1;
        repeat (4000) @(negedge clk);
        rd(8'h12, 8'h00);
        rd(8'h13, 8'h02);
        wr(8'h02, 8'h07);
        repeat (4000) @(negedge clk);
        rd(8'h13, 8'h06);
        chk("boost on", {10'h000, ben}, 11'h001);
        sht = 6'h01;
        repeat (60) @(negedge clk);
        sht = 6'h00;
        rd(8'h0F, 8'h04);
        chk("sinks", {5'h00, snk}, 11'h001);
        run = 0;
        repeat (3000) @(negedge clk);
        chk("boost", {10'h000, ben}, 11'h000);
        rd(8'h12, 8'hFF);
        hw = 0;
        @(negedge clk) hw = 1;
        chk("current", iled, 11'h000);
        rd(8'h14, 8'h44);
        repeat (3) @(negedge clk);
        tally_and_finish;
    end
endmodule : test_bld_ctrl
`default_nettype wire
